// File: hdl/no_protocol_serial_receive_consts.vh
// Constants for the no-protocol serial receive block
`ifndef NO_PROTOCOL_SERIAL_RECEIVE_CONSTS_VH
`define NO_PROTOCOL_SERIAL_RECEIVE_CONSTS_VH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define OFS_FRAME_CFG      12'h000
`define OFS_READ_CMD       12'h004
`define OFS_STATUS         12'h008
`define OFS_RX_COUNTS      12'h00C
`define OFS_RESTART        12'h010
`define OFS_DEST_BASE      12'h400
`define DEST_WORDS         128

// ----------------------------------------------------------------
// Frame configuration fields and reset value
// ----------------------------------------------------------------
`define CFG_NOPROTO_BUILTIN 0
`define CFG_NOPROTO_OPTION  1
`define CFG_START_EN        2
`define CFG_END_MODE_LO     3
`define CFG_START_LO        8
`define CFG_END_LO          16
`define CFG_COUNT_LO        24
`define CFG_RESET           32'h0000_0000
`define END_NONE            2'h0
`define END_CRLF            2'h1
`define END_BYTE            2'h2

// ----------------------------------------------------------------
// Read request fields: control word in 15:0, length in 31:16
// ----------------------------------------------------------------
`define CTL_ORDER_LO        0
`define CTL_MON_LO          4
`define CTL_PORT_LO         8
`define CMD_LEN_LO          16
`define PORT_BUILTIN        4'h1
`define PORT_OPTION         4'h2
`define ORDER_UPPER_FIRST   4'h0
`define ORDER_LOWER_FIRST   4'h1
`define MON_NONE            4'h0
`define MON_CTS             4'h1
`define MON_DSR             4'h2
`define MON_BOTH            4'h3

// ----------------------------------------------------------------
// Status bits and frame limits
// ----------------------------------------------------------------
`define ST_DONE_BUILTIN     0
`define ST_OVF_BUILTIN      1
`define ST_DONE_OPTION      8
`define ST_OVF_OPTION       9
`define ST_ERROR            16
`define ST_BUSY             17
`define MAX_DATA            9'h100
`define CHAR_CR             8'h0D
`define CHAR_LF             8'h0A

`endif

// File: hdl/no_protocol_serial_receive.v
// No-protocol serial receive block: framing, buffering and read-request engine
`timescale 1ns/1ps
// Operation
// - A read copies up to N buffered bytes, fewer if fewer arrived.
// - Port field value 1 selects built-in port, value 2 the option port.
// - Start code is absent or any single byte value.
// - End code absent, CR+LF or one byte; else count 1..256, zero means 256.
// - Count mode completes when configured count arrives; counter equals it.
// - End-code mode completes on end code or 256 data bytes.
// - Bytes beyond what the frame allows set overflow.
// - A read stores from the destination start, clears completion and counter.
// - Per-port restart bits clear completion and counter.
// - Completion, overflow and counter are kept per port.
// - Byte order in the destination follows control bits 3:0.
// - Monitor puts clear-to-send or data-ready in bit 15, both in 15 and 14.
// - Nonzero monitor code runs regardless of completion and stores no data.
// - Frame is at most 259 bytes; N counts data only, up to 256.
// - Length zero clears completion, overflow and counter, stores nothing.
// - Option port buffer is emptied after any read.
// - No new frame is taken until the previous one is read.
// - Reads serve only the two ports and only in no-protocol mode.
// - Error flag on bad mode, control word or length; cleared otherwise.
// - Reception counter runs 0 to 256.
`include "no_protocol_serial_receive_consts.vh"

module no_protocol_serial_receive (
    // Clock and reset
    input  wire        clk_i,
    input  wire        rst_i,
    // Wishbone slave
    input  wire        cyc_i,
    input  wire        stb_i,
    input  wire        we_i,
    input  wire [11:0] adr_i,
    input  wire [3:0]  sel_i,
    input  wire [31:0] dat_i,
    output reg  [31:0] dat_o,
    output reg         ack_o,
    // Received bytes, one strobe per byte, from same-clock receivers
    input  wire        rx_valid_builtin_i,
    input  wire [7:0]  rx_data_builtin_i,
    input  wire        rx_valid_option_i,
    input  wire [7:0]  rx_data_option_i,
    // Handshake line pins
    input  wire        cts_builtin_i,
    input  wire        dsr_builtin_i,
    input  wire        cts_option_i,
    input  wire        dsr_option_i,
    // Status outputs
    output wire        instruction_error_flag_o,
    output wire        busy_o
);

    localparam ST_IDLE = 3'b001;
    localparam ST_COPY = 3'b010;
    localparam ST_FIN  = 3'b100;

    // Smaller of two byte counts
    function [8:0] min9;
        input [8:0] a;
        input [8:0] b;
        begin
            min9 = (a < b) ? a : b;
        end
    endfunction

    // ----------------------------------------------------------------
    // Storage and state
    // ----------------------------------------------------------------
    reg  [31:0] frame_cfg;
    reg  [7:0]  rx_mem [0:511];
    reg  [7:0]  dest_mem [0:255];
    reg  [8:0]  rx_count [0:1];
    reg         done [0:1];
    reg         ovf [0:1];
    reg         started [0:1];
    reg         cr_seen [0:1];
    reg         error_flag;
    reg  [2:0]  state;
    reg         cur_port;
    reg  [3:0]  cur_order;
    reg  [8:0]  cur_len;
    reg  [8:0]  idx;
    reg  [3:0]  sync1;
    reg  [3:0]  sync2;
    reg  [1:0]  restart_req;
    reg  [1:0]  read_clear;
    reg  [1:0]  full_clear;

    wire        rx_valid [0:1];
    wire [7:0]  rx_data  [0:1];
    assign rx_valid[0] = rx_valid_builtin_i;
    assign rx_valid[1] = rx_valid_option_i;
    assign rx_data[0]  = rx_data_builtin_i;
    assign rx_data[1]  = rx_data_option_i;

    wire [1:0] end_mode   = frame_cfg[`CFG_END_MODE_LO +: 2];
    wire [7:0] start_code = frame_cfg[`CFG_START_LO +: 8];
    wire [7:0] end_code   = frame_cfg[`CFG_END_LO +: 8];
    wire [8:0] count_cfg  = (frame_cfg[`CFG_COUNT_LO +: 8] == 8'h00) ? `MAX_DATA
                                                                    : {1'b0, frame_cfg[`CFG_COUNT_LO +: 8]};

    // Bus request decode; request is taken in the cycle before ack
    wire        bus_take  = cyc_i & stb_i & ~ack_o;
    wire        bus_wr    = bus_take & we_i & (sel_i == 4'hF);
    wire [15:0] ctl_word  = dat_i[15:0];
    wire [15:0] len_word  = dat_i[`CMD_LEN_LO +: 16];
    wire [3:0]  ctl_order = ctl_word[`CTL_ORDER_LO +: 4];
    wire [3:0]  ctl_mon   = ctl_word[`CTL_MON_LO +: 4];
    wire [3:0]  ctl_port  = ctl_word[`CTL_PORT_LO +: 4];
    wire        req_port  = (ctl_port == `PORT_OPTION);

    wire ctl_ok  = ((ctl_port == `PORT_BUILTIN) || (ctl_port == `PORT_OPTION))
                 && (ctl_order <= `ORDER_LOWER_FIRST) && (ctl_mon <= `MON_BOTH)
                 && (ctl_word[15:12] == 4'h0);
    wire mode_ok = req_port ? frame_cfg[`CFG_NOPROTO_OPTION] : frame_cfg[`CFG_NOPROTO_BUILTIN];
    wire len_ok  = (len_word <= {7'h00, `MAX_DATA});
    wire cmd_wr  = bus_wr && (adr_i == `OFS_READ_CMD);
    wire cmd_go  = cmd_wr && (state == ST_IDLE) && ctl_ok && mode_ok && len_ok;

    assign instruction_error_flag_o = error_flag;
    assign busy_o                   = (state != ST_IDLE);

    // ----------------------------------------------------------------
    // Handshake line synchronisers
    // ----------------------------------------------------------------
    // Two flops per pin; only the second stage is read
    always @(posedge clk_i) begin
        if (rst_i) begin
            sync1 <= 4'h0;
            sync2 <= 4'h0;
        end else begin
            sync1 <= {dsr_option_i, cts_option_i, dsr_builtin_i, cts_builtin_i};
            sync2 <= sync1;
        end
    end

    // ----------------------------------------------------------------
    // Frame receivers, one per port
    // ----------------------------------------------------------------
    // Clears from restart or read win over an arriving byte in that cycle,
    // since the byte belongs to the frame being discarded.
    integer p;
    always @(posedge clk_i) begin
        if (rst_i) begin
            for (p = 0; p < 2; p = p + 1) begin
                rx_count[p] <= 9'h000;
                done[p]     <= 1'b0;
                ovf[p]      <= 1'b0;
                started[p]  <= 1'b0;
                cr_seen[p]  <= 1'b0;
            end
        end else begin
            for (p = 0; p < 2; p = p + 1) begin
                if (restart_req[p] || read_clear[p] || full_clear[p]) begin
                    rx_count[p] <= 9'h000;
                    done[p]     <= 1'b0;
                    started[p]  <= 1'b0;
                    cr_seen[p]  <= 1'b0;
                    if (full_clear[p])
                        ovf[p] <= 1'b0;
                end else if (rx_valid[p]) begin
                    if (done[p]) begin
                        ovf[p] <= 1'b1;
                    end else if (frame_cfg[`CFG_START_EN] && !started[p]) begin
                        if (rx_data[p] == start_code)
                            started[p] <= 1'b1;
                    end else if (end_mode == `END_CRLF && cr_seen[p] && rx_data[p] == `CHAR_LF) begin
                        // CR+LF ends frame; the stored CR is withdrawn
                        rx_count[p] <= rx_count[p] - 9'h001;
                        done[p]     <= 1'b1;
                    end else if (end_mode == `END_BYTE && rx_data[p] == end_code) begin
                        done[p] <= 1'b1;
                    end else begin
                        started[p]             <= 1'b1;
                        cr_seen[p]             <= (rx_data[p] == `CHAR_CR);
                        rx_mem[{p[0], rx_count[p][7:0]}] <= rx_data[p];
                        rx_count[p] <= rx_count[p] + 9'h001;
                        // count mode completes at configured count
                        if (end_mode == `END_NONE && rx_count[p] + 9'h001 == count_cfg)
                            done[p] <= 1'b1;
                        // 256 data bytes complete an end-code frame
                        if (end_mode != `END_NONE && rx_count[p] + 9'h001 == `MAX_DATA)
                            done[p] <= 1'b1;
                    end
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // Read request engine
    // ----------------------------------------------------------------
    // One byte per cycle; the destination keeps bytes so order is a pure index swap
    always @(posedge clk_i) begin
        if (rst_i) begin
            state      <= ST_IDLE;
            cur_port   <= 1'b0;
            cur_order  <= 4'h0;
            cur_len    <= 9'h000;
            idx        <= 9'h000;
            error_flag <= 1'b0;
            read_clear <= 2'b00;
            full_clear <= 2'b00;
        end else begin
            read_clear <= 2'b00;
            full_clear <= 2'b00;
            case (state)
                ST_IDLE: begin
                    // error set or cleared per request
                    if (cmd_wr && state == ST_IDLE)
                        error_flag <= ~(ctl_ok && mode_ok && len_ok);
                    if (cmd_go) begin
                        cur_port  <= req_port;
                        cur_order <= ctl_order;
                        idx       <= 9'h000;
                        if (ctl_mon != `MON_NONE) begin
                            dest_mem[0] <= (ctl_mon == `MON_BOTH) ? {sync2[{req_port, 1'b0}],
                                                                    sync2[{req_port, 1'b1}], 6'h00}
                                         : (ctl_mon == `MON_CTS) ? {sync2[{req_port, 1'b0}], 7'h00}
                                         : {sync2[{req_port, 1'b1}], 7'h00};
                            dest_mem[1] <= 8'h00;
                        end else if (len_word[8:0] == 9'h000) begin
                            full_clear[req_port] <= 1'b1;
                        end else begin
                            cur_len <= min9(len_word[8:0], rx_count[req_port]);
                            state   <= ST_COPY;
                        end
                    end
                end
                ST_COPY: begin
                    if (idx < cur_len) begin
                        dest_mem[(cur_order == `ORDER_LOWER_FIRST) ? (idx[7:0] ^ 8'h01) : idx[7:0]]
                            <= rx_mem[{cur_port, idx[7:0]}];
                        idx <= idx + 9'h001;
                    end else begin
                        state <= ST_FIN;
                    end
                end
                ST_FIN: begin
                    // completion and counter cleared after the copy
                    read_clear[cur_port] <= 1'b1;
                    if (cur_port)
                        full_clear[1] <= 1'b1;
                    state <= ST_IDLE;
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Wishbone register access
    // ----------------------------------------------------------------
    // Answer one cycle after the request; unmapped reads return zero
    wire [7:0] dest_idx = {adr_i[8:2], 1'b0};
    always @(posedge clk_i) begin
        if (rst_i) begin
            ack_o       <= 1'b0;
            dat_o       <= 32'h0000_0000;
            frame_cfg   <= `CFG_RESET;
            restart_req <= 2'b00;
        end else begin
            ack_o       <= bus_take;
            restart_req <= 2'b00;
            if (bus_wr && adr_i == `OFS_FRAME_CFG)
                frame_cfg <= dat_i;
            if (bus_wr && adr_i == `OFS_RESTART)
                restart_req <= dat_i[1:0];
            if (bus_take && !we_i) begin
                if (adr_i == `OFS_FRAME_CFG)
                    dat_o <= frame_cfg;
                else if (adr_i == `OFS_STATUS)
                    dat_o <= {14'h0000, busy_o, error_flag, 6'h00, ovf[1], done[1], 6'h00, ovf[0], done[0]};
                else if (adr_i == `OFS_RX_COUNTS)
                    dat_o <= {7'h00, rx_count[1], 7'h00, rx_count[0]};
                else if (adr_i >= `OFS_DEST_BASE && adr_i[11:10] == 2'b01 && adr_i[9] == 1'b0)
                    dat_o <= {16'h0000, dest_mem[dest_idx], dest_mem[dest_idx + 8'h01]};
                else
                    dat_o <= 32'h0000_0000;
            end
        end
    end

endmodule // no_protocol_serial_receive

// File: verification/np_rx_asserts.sv
// Checker for the no-protocol serial receive block ports
`timescale 1ns/1ps
`include "no_protocol_serial_receive_consts.vh"
module np_rx_asserts (
    input wire        clk_i,
    input wire        rst_i,
    input wire        cyc_i,
    input wire        stb_i,
    input wire        we_i,
    input wire [11:0] adr_i,
    input wire [3:0]  sel_i,
    input wire [31:0] dat_i,
    input wire [31:0] dat_o,
    input wire        ack_o,
    input wire        instruction_error_flag_o,
    input wire        busy_o
);
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    wire      take   = cyc_i && stb_i && !ack_o;
    wire      cmd_wr = take && we_i && adr_i == `OFS_READ_CMD && sel_i == 4'hF && !busy_o;
    reg [9:0] busy_len;
    // Busy run length; the copy never exceeds 256 bytes plus two steps
    always @(posedge clk_i) begin
        if (rst_i || !busy_o) busy_len <= 10'h000;
        else busy_len <= busy_len + 10'h001;
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    chk_ack_after_take: assert property (take |=> ack_o) else $error("ack missing after request");
    chk_ack_single_pulse: assert property (ack_o |=> !ack_o) else $error("ack longer than one cycle");
    chk_no_stray_ack: assert property (!take |=> !ack_o) else $error("ack without request");
    chk_reset_quiet_outputs: assert property ($fell(rst_i) |-> !ack_o && !busy_o &&
        !instruction_error_flag_o && dat_o == 32'h0000_0000) else $error("outputs not cleared by reset");
    chk_bad_port_error: assert property (cmd_wr && dat_i[11:8] != `PORT_BUILTIN &&
        dat_i[11:8] != `PORT_OPTION |-> ##[1:2] instruction_error_flag_o) else $error("bad port not flagged");
    chk_long_len_error: assert property (cmd_wr && dat_i[31:16] > 16'h0100
        |-> ##[1:2] instruction_error_flag_o) else $error("length over 256 not flagged");
    chk_monitor_no_copy: assert property (cmd_wr && dat_i[7:4] != `MON_NONE
        |=> !busy_o [*2]) else $error("monitor request started a copy");
    chk_read_data_hold: assert property (!(take && !we_i) |=> $stable(dat_o)) else $error("read data moved");
    chk_copy_length_bound: assert property (busy_len < 10'd259)
        else $error("copy longer than a full frame");
    cov_copy: cover property (cmd_wr && dat_i[7:4] == `MON_NONE);
    cov_busy: cover property ($rose(busy_o));
    cov_error: cover property ($rose(instruction_error_flag_o));
endmodule // np_rx_asserts

// File: verification/serial_device_model.sv
// External serial device model: byte strobes and handshake lines for both ports
`timescale 1ns/1ps
module serial_device_model (
    input  wire       clk_i,
    output reg        rx_valid_builtin_o,
    output reg  [7:0] rx_data_builtin_o,
    output reg        rx_valid_option_o,
    output reg  [7:0] rx_data_option_o,
    output reg        cts_builtin_o,
    output reg        dsr_builtin_o,
    output reg        cts_option_o,
    output reg        dsr_option_o
);
    initial begin
        {rx_valid_builtin_o, rx_valid_option_o} = 2'b00;
        {rx_data_builtin_o, rx_data_option_o}   = 16'h0000;
        {cts_builtin_o, dsr_builtin_o, cts_option_o, dsr_option_o} = 4'h0;
    end
    // one byte strobe per call; data shows the inverse once released
    task send(input bit opt, input [7:0] b);
        @(posedge clk_i);
        if (opt) {rx_valid_option_o, rx_data_option_o} <= {1'b1, b};
        else {rx_valid_builtin_o, rx_data_builtin_o} <= {1'b1, b};
        @(posedge clk_i);
        if (opt) {rx_valid_option_o, rx_data_option_o} <= {1'b0, ~b};
        else {rx_valid_builtin_o, rx_data_builtin_o} <= {1'b0, ~b};
    endtask
    // Handshake levels change only between requests
    task lines(input [3:0] v);
        @(posedge clk_i);
        {cts_builtin_o, dsr_builtin_o, cts_option_o, dsr_option_o} <= v;
    endtask
endmodule // serial_device_model

// File: verification/tb.sv
// Testbench for the no-protocol serial receive block
`timescale 1ns/1ps
`include "no_protocol_serial_receive_consts.vh"
module tb;
    reg         clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
    reg  [11:0] adr_i = 12'h000;
    reg  [3:0]  sel_i = 4'h0;
    reg  [31:0] dat_i = 32'h0000_0000, rd;
    wire [31:0] dat_o;
    wire        ack_o, err, busy_o, vb, vo, cb, db, co, dop;
    wire [7:0]  xb, xo;
    int         fails = 0, comparisons = 0, cycles = 0;
    byte unsigned xs[6] = '{8'h55, 8'h02, 8'ha1, 8'hb2, 8'hc3, 8'h03};
    always #2 clk_i = ~clk_i;
    no_protocol_serial_receive DUT (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
        .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
        .rx_valid_builtin_i(vb), .rx_data_builtin_i(xb), .rx_valid_option_i(vo), .rx_data_option_i(xo),
        .cts_builtin_i(cb), .dsr_builtin_i(db), .cts_option_i(co), .dsr_option_i(dop),
        .instruction_error_flag_o(err), .busy_o(busy_o));
    serial_device_model dev (.clk_i(clk_i), .rx_valid_builtin_o(vb), .rx_data_builtin_o(xb),
        .rx_valid_option_o(vo), .rx_data_option_o(xo), .cts_builtin_o(cb), .dsr_builtin_o(db),
        .cts_option_o(co), .dsr_option_o(dop));
    // ----------------------------------------
    // Bus tasks and comparison
    // ----------------------------------------
    task results();
        if (fails == 0 && comparisons > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task wb(input bit w, input [11:0] a, input [31:0] d);
        @(posedge clk_i);
        {cyc_i, stb_i, we_i, adr_i, sel_i, dat_i} <= {2'b11, w, a, 4'hF, d};
        do @(posedge clk_i); while (ack_o !== 1'b1);
        rd = dat_o;
        {cyc_i, stb_i, we_i} <= 3'b000;
    endtask
    task chk(input string n, input [31:0] e, input [31:0] g);
        comparisons++;
        if (g !== e) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask
    task rchk(input string n, input [11:0] a, input [31:0] e);
        wb(1'b0, a, 32'h0000_0000);
        chk(n, e, rd);
    endtask
    // Read request, then wait out the copy and the flag clear
    task cmd(input [8:0] n, input [3:0] port, input [3:0] mon, input [3:0] ord);
        wb(1'b1, `OFS_READ_CMD, {7'h00, n, 4'h0, port, mon, ord});
        while (busy_o !== 1'b0) @(posedge clk_i);
        repeat (4) @(posedge clk_i);
    endtask
    function [31:0] cfgw(input [2:0] en, input [1:0] em, input [7:0] sc, input [7:0] ec, input [7:0] cn);
        cfgw = {cn, ec, sc, 3'b000, em, en};
    endfunction
    // Hang guard far above the several hundred cycles the sequence needs
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            fails++;
            results();
        end
    end
    // ----------------------------------------
    // Sequence
    // ----------------------------------------
    initial begin
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        rchk("cfg reset", `OFS_FRAME_CFG, `CFG_RESET);
        rchk("status reset", `OFS_STATUS, 32'h0000_0000);
        rchk("unmapped", 12'h100, 32'h0000_0000);
        // Count mode of four, then one byte too many
        wb(1'b1, `OFS_FRAME_CFG, cfgw(3'b011, `END_NONE, 8'h00, 8'h00, 8'h04));
        for (int k = 1; k <= 5; k++) dev.send(1'b0, 8'h11 * k);
        rchk("count done ovf", `OFS_STATUS, 32'h0000_0003);
        rchk("count four", `OFS_RX_COUNTS, 32'h0000_0004);
        cmd(9'd4, `PORT_BUILTIN, `MON_NONE, `ORDER_UPPER_FIRST);
        rchk("dest word0", `OFS_DEST_BASE, 32'h0000_1122);
        rchk("dest word1", `OFS_DEST_BASE + 12'h004, 32'h0000_3344);
        rchk("read clears done", `OFS_STATUS, 32'h0000_0002);
        rchk("read clears count", `OFS_RX_COUNTS, 32'h0000_0000);
        cmd(9'd0, `PORT_BUILTIN, `MON_NONE, `ORDER_UPPER_FIRST);
        rchk("zero length clears", `OFS_STATUS, 32'h0000_0000);
        // Option port with start and end byte, noise before the start
        wb(1'b1, `OFS_FRAME_CFG, cfgw(3'b111, `END_BYTE, 8'h02, 8'h03, 8'h00));
        foreach (xs[k]) dev.send(1'b1, xs[k]);
        rchk("end code done", `OFS_STATUS, 32'h0000_0100);
        rchk("option count", `OFS_RX_COUNTS, 32'h0003_0000);
        cmd(9'd8, `PORT_OPTION, `MON_NONE, `ORDER_LOWER_FIRST);
        rchk("lower first", `OFS_DEST_BASE, 32'h0000_b2a1);
        rchk("option emptied", `OFS_STATUS, 32'h0000_0000);
        rchk("option count clear", `OFS_RX_COUNTS, 32'h0000_0000);
        // CR+LF frame, cleared by restart
        wb(1'b1, `OFS_FRAME_CFG, cfgw(3'b011, `END_CRLF, 8'h00, 8'h00, 8'h00));
        dev.send(1'b0, 8'h78);
        dev.send(1'b0, `CHAR_CR);
        dev.send(1'b0, `CHAR_LF);
        rchk("crlf done", `OFS_STATUS, 32'h0000_0001);
        rchk("crlf count", `OFS_RX_COUNTS, 32'h0000_0001);
        wb(1'b1, `OFS_RESTART, 32'h0000_0001);
        rchk("restart done", `OFS_STATUS, 32'h0000_0000);
        rchk("restart count", `OFS_RX_COUNTS, 32'h0000_0000);
        // Count setting zero means a full 256 byte frame
        wb(1'b1, `OFS_FRAME_CFG, cfgw(3'b011, `END_NONE, 8'h00, 8'h00, 8'h00));
        for (int k = 0; k < 256; k++) dev.send(1'b0, k[7:0]);
        rchk("full frame", `OFS_STATUS, 32'h0000_0001);
        rchk("count 256", `OFS_RX_COUNTS, 32'h0000_0100);
        wb(1'b1, `OFS_RESTART, 32'h0000_0001);
        // Bad requests raise the error flag, a good one clears it
        cmd(9'd1, 4'h3, `MON_NONE, `ORDER_UPPER_FIRST);
        chk("bad port", 32'h0000_0001, {31'h0, err});
        cmd(9'd1, `PORT_BUILTIN, `MON_NONE, `ORDER_UPPER_FIRST);
        chk("good clears", 32'h0000_0000, {31'h0, err});
        wb(1'b1, `OFS_READ_CMD, {16'h0101, 4'h0, `PORT_BUILTIN, 8'h00});
        rchk("long length", `OFS_STATUS, 32'h0001_0000);
        wb(1'b1, `OFS_FRAME_CFG, cfgw(3'b010, `END_NONE, 8'h00, 8'h00, 8'h00));
        cmd(9'd1, `PORT_BUILTIN, `MON_NONE, `ORDER_UPPER_FIRST);
        chk("mode off", 32'h0000_0001, {31'h0, err});
        // Handshake monitoring writes line status, no data
        wb(1'b1, `OFS_FRAME_CFG, cfgw(3'b011, `END_NONE, 8'h00, 8'h00, 8'h00));
        dev.lines(4'b1001);
        repeat (4) @(posedge clk_i);
        cmd(9'd2, `PORT_BUILTIN, `MON_BOTH, `ORDER_UPPER_FIRST);
        rchk("mon both", `OFS_DEST_BASE, 32'h0000_8000);
        cmd(9'd2, `PORT_OPTION, `MON_DSR, `ORDER_UPPER_FIRST);
        rchk("mon dsr", `OFS_DEST_BASE, 32'h0000_8000);
        cmd(9'd2, `PORT_OPTION, `MON_CTS, `ORDER_UPPER_FIRST);
        rchk("mon cts", `OFS_DEST_BASE, 32'h0000_0000);
        results();
    end
endmodule // tb
bind no_protocol_serial_receive np_rx_asserts chk_i (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
    .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .instruction_error_flag_o(instruction_error_flag_o), .busy_o(busy_o));
